// ---- src/flash_status_pkg.sv ----
// Purpose: Constants for the flash status and error-status flag block
// Assumes: APB register access, 32-bit data, one word per register
// Notes: Offsets of all registers are chosen locally
// What this block does
// R01: Writing one to command-done launches a command; flag low until finish or reject.
// R02: Access-fault flag sets on command sequence violation or illegal command.
// R03: While access-fault is set, command-done writes are ignored; no launch.
// R04: Access-fault clears only by writing one; zero leaves it.
// R05: Protect-violation flag sets on program or erase into a protected region.
// R06: Protect-violation clears only by writing one; zero has no effect.
// R07: While protect-violation is set, no sequence start and no launch.
// R08: Engine-busy reads one while a command executes, zero when idle.
// R09: Status bit 2 is reserved, reads zero, ignores writes.
// R10: Completion-status bits set on command or reset-sequence error.
// R11: Only done, access and protect bits writable; busy and status read-only.
// R12: Double-fault sets on uncorrectable read fault or read during busy.
// R13: Double-fault clears only by writing one; zero leaves it.
// R14: Unless suppressed, single-fault sets on corrected fault or read during busy.
// R15: Single-fault clears only by writing one; zero has no effect.
// R16: A genuine ECC fault sets single or double, never both.
// R17: A read colliding with a running command sets double-fault, and single-fault unless ignore-single-fault is set.
// R18: Status after reset may differ when reset reads a double-bit fault.
// R19: With completion enable, request interrupt while command-done is set.
// R20: Fault interrupts request while each fault flag and its enable are set.
// R21: Ignore-single-fault suppresses single-fault reporting and its interrupt.
// R22: A set event in the same cycle as a clear keeps the flag set.
package flash_status_pkg;
  localparam logic [11:0] STATUS_OFF = 12'h000;
  localparam logic [11:0] ERROR_STATUS_OFF = 12'h004;
  localparam logic [11:0] CONFIG_OFF = 12'h008;
  localparam logic [11:0] ERROR_CONFIG_OFF = 12'h00c;
  localparam int DONE_BIT = 7;
  localparam int ACCESS_BIT = 5;
  localparam int PROTECT_BIT = 4;
  localparam int BUSY_BIT = 3;
  localparam int CSTAT_LSB = 0;
  localparam int DOUBLE_BIT = 1;
  localparam int SINGLE_BIT = 0;
  localparam int CFG_CIE_BIT = 7;
  localparam int CFG_IGN_BIT = 4;
  localparam int ECFG_DIE_BIT = 1;
  localparam int ECFG_SIE_BIT = 0;
  localparam logic DONE_RESET = 1'b1;
  localparam logic [1:0] CSTAT_RESET = 2'h0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] ERROR_CONFIG_RESET = 8'h00;
endpackage : flash_status_pkg

// ---- src/flash_status_flags.sv ----
// Purpose: Status and error-status flags of the flash command controller
// Assumes: Single clock; engine and ECC path strobes are one-cycle pulses
// Notes: Unmapped addresses read zero and answer with PSLVERR
//
// Chosen here: the APB slave port and the register offsets.
module flash_status_flags (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SEQ_VIOLATION_I,
  input wire logic ILLEGAL_CMD_I,
  input wire logic PROTECT_HIT_I,
  input wire logic SEQ_START_I,
  input wire logic CMD_DONE_I,
  input wire logic [1:0] CMD_STATUS_I,
  input wire logic RESET_SEQ_DONE_I,
  input wire logic RESET_SEQ_DFAULT_I,
  input wire logic READ_SINGLE_I,
  input wire logic READ_DOUBLE_I,
  input wire logic READ_COLLIDE_I,
  output logic CMD_LAUNCH_O,
  output logic SEQ_ALLOW_O,
  output logic ENGINE_BUSY_O,
  output logic IRQ_DONE_O,
  output logic IRQ_DOUBLE_O,
  output logic IRQ_SINGLE_O
);
  logic command_done_flag_ff;
  logic access_fault_flag_ff;
  logic protect_violation_flag_ff;
  logic engine_busy_ff;
  logic [1:0] completion_status_ff;
  logic double_fault_flag_ff;
  logic single_fault_flag_ff;
  logic [7:0] flash_config_ff;
  logic [7:0] flash_error_config_ff;
  logic [31:0] prdata_ff;
  logic wr_en;
  logic rd_en;
  logic hit_status;
  logic hit_error;
  logic hit_config;
  logic hit_error_config;
  logic mapped;
  logic launch;
  logic ignore_single_fault;
  logic single_set;
  logic double_set;
  logic [7:0] status_view;
  logic [7:0] error_view;
  logic [31:0] nxt_prdata;

  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = PSEL_I && PENABLE_I && !PWRITE_I;
  assign hit_status = (PADDR_I == flash_status_pkg::STATUS_OFF);
  assign hit_error = (PADDR_I == flash_status_pkg::ERROR_STATUS_OFF);
  assign hit_config = (PADDR_I == flash_status_pkg::CONFIG_OFF);
  assign hit_error_config = (PADDR_I == flash_status_pkg::ERROR_CONFIG_OFF);
  assign mapped = hit_status || hit_error || hit_config || hit_error_config;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign PRDATA_O = prdata_ff;
  assign ignore_single_fault = flash_config_ff[flash_status_pkg::CFG_IGN_BIT];

  // Launch only when no fault flag blocks it (see R03) (see R07)
  assign launch = wr_en && hit_status && PWDATA_I[flash_status_pkg::DONE_BIT]
    && command_done_flag_ff && !access_fault_flag_ff && !protect_violation_flag_ff; // see R01
  assign CMD_LAUNCH_O = launch;
  assign SEQ_ALLOW_O = command_done_flag_ff && !protect_violation_flag_ff; // see R07
  assign ENGINE_BUSY_O = engine_busy_ff;

  // Collision sets double and, unless ignored, single; ECC fault sets one only (see R16) (see R17)
  assign double_set = READ_COLLIDE_I || (READ_DOUBLE_I && !READ_SINGLE_I); // see R12
  assign single_set = !ignore_single_fault
    && (READ_COLLIDE_I || (READ_SINGLE_I && !READ_DOUBLE_I)); // see R14 see R21

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      command_done_flag_ff <= flash_status_pkg::DONE_RESET;
    end else if (launch) begin
      command_done_flag_ff <= 1'b0; // see R01
    end else if (CMD_DONE_I && !command_done_flag_ff) begin
      command_done_flag_ff <= 1'b1; // see R01
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      engine_busy_ff <= 1'b0;
    end else if (launch) begin
      engine_busy_ff <= 1'b1; // see R08
    end else if (CMD_DONE_I) begin
      engine_busy_ff <= 1'b0; // see R08
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      access_fault_flag_ff <= 1'b0;
    end else if (SEQ_VIOLATION_I || ILLEGAL_CMD_I) begin
      access_fault_flag_ff <= 1'b1; // see R02 see R22
    end else if (wr_en && hit_status && PWDATA_I[flash_status_pkg::ACCESS_BIT]) begin
      access_fault_flag_ff <= 1'b0; // see R04
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      protect_violation_flag_ff <= 1'b0;
    end else if (PROTECT_HIT_I) begin
      protect_violation_flag_ff <= 1'b1; // see R05 see R22
    end else if (wr_en && hit_status && PWDATA_I[flash_status_pkg::PROTECT_BIT]) begin
      protect_violation_flag_ff <= 1'b0; // see R06
    end
  end

  // Completion status loads at command end and reset-sequence end
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      completion_status_ff <= flash_status_pkg::CSTAT_RESET;
    end else if (RESET_SEQ_DONE_I) begin
      completion_status_ff <= {RESET_SEQ_DFAULT_I, 1'b0}; // see R10 see R18
    end else if (launch) begin
      completion_status_ff <= flash_status_pkg::CSTAT_RESET;
    end else if (CMD_DONE_I) begin
      completion_status_ff <= CMD_STATUS_I; // see R10
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      double_fault_flag_ff <= 1'b0;
    end else if (double_set || (RESET_SEQ_DONE_I && RESET_SEQ_DFAULT_I)) begin
      double_fault_flag_ff <= 1'b1; // see R12 see R22
    end else if (wr_en && hit_error && PWDATA_I[flash_status_pkg::DOUBLE_BIT]) begin
      double_fault_flag_ff <= 1'b0; // see R13
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      single_fault_flag_ff <= 1'b0;
    end else if (single_set) begin
      single_fault_flag_ff <= 1'b1; // see R14 see R22
    end else if (wr_en && hit_error && PWDATA_I[flash_status_pkg::SINGLE_BIT]) begin
      single_fault_flag_ff <= 1'b0; // see R15
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      flash_config_ff <= flash_status_pkg::CONFIG_RESET;
      flash_error_config_ff <= flash_status_pkg::ERROR_CONFIG_RESET;
    end else if (wr_en && hit_config) begin
      flash_config_ff[flash_status_pkg::CFG_CIE_BIT] <= PWDATA_I[flash_status_pkg::CFG_CIE_BIT];
      flash_config_ff[flash_status_pkg::CFG_IGN_BIT] <= PWDATA_I[flash_status_pkg::CFG_IGN_BIT];
    end else if (wr_en && hit_error_config) begin
      flash_error_config_ff[flash_status_pkg::ECFG_DIE_BIT] <=
        PWDATA_I[flash_status_pkg::ECFG_DIE_BIT];
      flash_error_config_ff[flash_status_pkg::ECFG_SIE_BIT] <=
        PWDATA_I[flash_status_pkg::ECFG_SIE_BIT];
    end
  end

  // Read views; reserved bits read zero (see R09) (see R11)
  always_comb begin
    status_view = 8'h00;
    status_view[flash_status_pkg::DONE_BIT] = command_done_flag_ff;
    status_view[flash_status_pkg::ACCESS_BIT] = access_fault_flag_ff;
    status_view[flash_status_pkg::PROTECT_BIT] = protect_violation_flag_ff;
    status_view[flash_status_pkg::BUSY_BIT] = engine_busy_ff && !command_done_flag_ff; // see R08
    status_view[flash_status_pkg::CSTAT_LSB +: 2] = completion_status_ff;
    error_view = 8'h00;
    error_view[flash_status_pkg::DOUBLE_BIT] = double_fault_flag_ff;
    error_view[flash_status_pkg::SINGLE_BIT] = single_fault_flag_ff;
  end

  always_comb begin
    nxt_prdata = 32'h00000000;
    if (hit_status) begin
      nxt_prdata = {24'h000000, status_view};
    end else if (hit_error) begin
      nxt_prdata = {24'h000000, error_view};
    end else if (hit_config) begin
      nxt_prdata = {24'h000000, flash_config_ff};
    end else if (hit_error_config) begin
      nxt_prdata = {24'h000000, flash_error_config_ff};
    end
  end

  // Read data registered in the setup cycle, valid through the access phase
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      prdata_ff <= 32'h00000000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      prdata_ff <= nxt_prdata;
    end else if (rd_en) begin
      prdata_ff <= prdata_ff;
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      IRQ_DONE_O <= 1'b0;
      IRQ_DOUBLE_O <= 1'b0;
      IRQ_SINGLE_O <= 1'b0;
    end else begin
      IRQ_DONE_O <= command_done_flag_ff && flash_config_ff[flash_status_pkg::CFG_CIE_BIT]; // see R19
      IRQ_DOUBLE_O <= double_fault_flag_ff
        && flash_error_config_ff[flash_status_pkg::ECFG_DIE_BIT]; // see R20
      IRQ_SINGLE_O <= single_fault_flag_ff && !ignore_single_fault
        && flash_error_config_ff[flash_status_pkg::ECFG_SIE_BIT]; // see R20 see R21
    end
  end
endmodule : flash_status_flags

// ---- dv/flash_status_flags_assertions.sv ----
// Purpose: Port-level checks of the flash status flag block
// Assumes: Single clock domain, async active-high reset
// Notes: Bound from the testbench top file
module flash_status_flags_assertions (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PROTECT_HIT_I,
  input wire logic CMD_DONE_I,
  input wire logic RESET_SEQ_DONE_I,
  input wire logic READ_SINGLE_I,
  input wire logic READ_DOUBLE_I,
  input wire logic READ_COLLIDE_I,
  input wire logic CMD_LAUNCH_O,
  input wire logic SEQ_ALLOW_O,
  input wire logic ENGINE_BUSY_O,
  input wire logic IRQ_DONE_O,
  input wire logic IRQ_DOUBLE_O,
  input wire logic IRQ_SINGLE_O
);
  logic wr;
  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RESET_I);
  property p_launch_cause;
    CMD_LAUNCH_O |-> wr && PADDR_I == 12'h000 && PWDATA_I[7];
  endproperty
  a_launch_cause: assert property (p_launch_cause) else $error("stray launch");
  property p_launch_busy;
    CMD_LAUNCH_O |=> ENGINE_BUSY_O;
  endproperty
  a_launch_busy: assert property (p_launch_busy) else $error("no busy");
  property p_launch_allow;
    CMD_LAUNCH_O |-> SEQ_ALLOW_O;
  endproperty
  a_launch_allow: assert property (p_launch_allow) else $error("blocked launch");
  property p_protect_block;
    PROTECT_HIT_I |=> !SEQ_ALLOW_O;
  endproperty
  a_protect_block: assert property (p_protect_block) else $error("allow");
  property p_done_idle;
    CMD_DONE_I && ENGINE_BUSY_O |=> !ENGINE_BUSY_O;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy stuck");
  property p_irq_done;
    IRQ_DONE_O |-> !$past(ENGINE_BUSY_O);
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("done irq");
  property p_irq_single;
    $rose(IRQ_SINGLE_O) |-> $past(READ_SINGLE_I || READ_COLLIDE_I || wr, 2);
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("single irq");
  property p_irq_double;
    $rose(IRQ_DOUBLE_O) |-> $past(READ_DOUBLE_I || READ_COLLIDE_I || RESET_SEQ_DONE_I || wr, 2);
  endproperty
  a_irq_double: assert property (p_irq_double) else $error("double irq");
  c_launch: cover property (CMD_LAUNCH_O);
  c_collide: cover property (READ_COLLIDE_I);
  c_dirq: cover property ($rose(IRQ_DOUBLE_O));
endmodule : flash_status_flags_assertions

// ---- dv/flash_status_flags_tb_top.sv ----
// Purpose: Directed testbench of the flash status flag block
// Assumes: Zero-wait APB slave
// Notes: Event strobes packed into one vector
module flash_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK_I = 1'b0, RESET_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [11:0] PADDR_I = 12'h000;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd;
  logic slverr;
  logic PREADY_O, PSLVERR_O, CMD_LAUNCH_O, SEQ_ALLOW_O, ENGINE_BUSY_O;
  logic IRQ_DONE_O, IRQ_DOUBLE_O, IRQ_SINGLE_O, SEQ_START_I = 1'b0;
  logic SEQ_VIOLATION_I = 1'b0, ILLEGAL_CMD_I = 1'b0, PROTECT_HIT_I = 1'b0, CMD_DONE_I = 1'b0;
  logic [1:0] CMD_STATUS_I = 2'h0;
  logic RESET_SEQ_DONE_I = 1'b0, RESET_SEQ_DFAULT_I = 1'b0;
  logic READ_SINGLE_I = 1'b0, READ_DOUBLE_I = 1'b0, READ_COLLIDE_I = 1'b0;
  int error_cnt = 0, n_checks = 0;
  always #2 MCLK_I = ~MCLK_I;
  flash_status_flags dut (.*);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge MCLK_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge MCLK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 16);
    rd = PRDATA_O;
    slverr = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge MCLK_I);
    if (n >= 16) begin
      error_cnt++;
      give_verdict();
    end
  endtask : apb
  task automatic ev(input logic [7:0] m);
    {SEQ_VIOLATION_I, ILLEGAL_CMD_I, PROTECT_HIT_I, CMD_DONE_I, RESET_SEQ_DONE_I,
     READ_SINGLE_I, READ_DOUBLE_I, READ_COLLIDE_I} <= m;
    @(posedge MCLK_I);
    {SEQ_VIOLATION_I, ILLEGAL_CMD_I, PROTECT_HIT_I, CMD_DONE_I, RESET_SEQ_DONE_I,
     READ_SINGLE_I, READ_DOUBLE_I, READ_COLLIDE_I} <= 8'h00;
  endtask : ev
  task automatic t_cmd();
    apb(0, 12'h000, 0);
    chk("status", rd, 32'h80);
    apb(1, 12'h000, 32'h80);
    apb(0, 12'h000, 0);
    chk("busy", rd, 32'h08);
    CMD_STATUS_I <= 2'h2;
    ev(8'h10);
    apb(0, 12'h000, 0);
    chk("cstat", rd, 32'h82);
    apb(1, 12'h000, 32'h0f);
    apb(0, 12'h000, 0);
    chk("ro", rd, 32'h82);
    apb(0, 12'h010, 0);
    chk("unmapped", {rd[30:0], slverr}, 32'h1);
    $display("command test done");
  endtask : t_cmd
  task automatic t_flag(input logic [7:0] m, input logic [31:0] b);
    ev(m);
    apb(1, 12'h000, 32'h80);
    apb(0, 12'h000, 0);
    chk("refuse", rd & 32'hfc, 32'h80 | b);
    chk("allow", SEQ_ALLOW_O, b != 32'h20 ? 0 : 1);
    apb(1, 12'h000, 0);
    apb(0, 12'h000, 0);
    chk("w0", rd & 32'hfc, 32'h80 | b);
    apb(1, 12'h000, b);
    apb(0, 12'h000, 0);
    chk("w1c", rd & 32'hfc, 32'h80);
    $display("flag test done");
  endtask : t_flag
  task automatic t_err(input logic [7:0] m, input logic [31:0] e);
    ev(m);
    apb(0, 12'h004, 0);
    chk("errstat", rd, e);
    apb(1, 12'h004, 0);
    apb(0, 12'h004, 0);
    chk("w0", rd, e);
    chk("irq", {IRQ_DOUBLE_O, IRQ_SINGLE_O}, e);
    apb(1, 12'h004, 32'h3);
    $display("fault test done");
  endtask : t_err
  initial begin
    repeat (6) @(posedge MCLK_I);
    RESET_I <= 1'b0;
    @(posedge MCLK_I);
    t_cmd();
    t_flag(8'h80, 32'h20);
    t_flag(8'h40, 32'h20);
    t_flag(8'h20, 32'h10);
    apb(1, 12'h00c, 32'h3);
    apb(1, 12'h008, 32'h80);
    t_err(8'h04, 32'h1);
    t_err(8'h02, 32'h2);
    t_err(8'h01, 32'h3);
    chk("irqdone", IRQ_DONE_O, 1);
    fork
      apb(1, 12'h004, 32'h2);
      begin
        @(posedge MCLK_I);
        ev(8'h02);
      end
    join
    t_err(8'h00, 32'h2);
    apb(1, 12'h008, 32'h10);
    t_err(8'h04, 32'h0);
    RESET_SEQ_DFAULT_I <= 1'b1;
    t_err(8'h08, 32'h2);
    apb(0, 12'h000, 0);
    chk("rstseq", rd & 32'h2, 32'h2);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge MCLK_I);
    error_cnt++;
    give_verdict();
  end
endmodule : flash_status_flags_tb_top
bind flash_status_flags flash_status_flags_assertions u_chk (.*);
